/* common/icc_pkg.sv */
// Purpose: shared constants for the four-channel input capture unit
// Assumes: 32-bit classic Wishbone, printed offsets are word indices
// Notes:   byte address of a register is four times its index
package icc_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NCH   = 4;
  localparam int TS_W  = 16;
  localparam int DEPTH = 4;
  localparam int IDX_W = 10;

  // ----------------------------------------------------------------
  // register indices: first, second, seventh, eighth channel
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] BUF_IDX [0:NCH-1] =
    '{10'h140, 10'h144, 10'h158, 10'h15C};
  localparam logic [IDX_W-1:0] CTRL_IDX [0:NCH-1] =
    '{10'h142, 10'h146, 10'h15A, 10'h15E};

  // ----------------------------------------------------------------
  // channel_control_reg fields
  // ----------------------------------------------------------------
  localparam int MODE_LSB = 0;
  localparam int NE_BIT   = 3;
  localparam int OVF_BIT  = 4;
  localparam int EPI_LSB  = 5;
  localparam int TB_BIT   = 7;
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [1:0] EPI_RESET  = 2'h0;
  localparam logic       TB_RESET   = 1'b0;

  // ----------------------------------------------------------------
  // capture_mode_sel encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_OFF    = 3'h0;
  localparam logic [2:0] MODE_EVERY  = 3'h1;
  localparam logic [2:0] MODE_FALL   = 3'h2;
  localparam logic [2:0] MODE_RISE   = 3'h3;
  localparam logic [2:0] MODE_RISE4  = 3'h4;
  localparam logic [2:0] MODE_RISE16 = 3'h5;
  localparam logic [2:0] MODE_WAKE   = 3'h7;

  // prescaler terminal counts (count of rising edges minus one)
  localparam logic [3:0] PRESC4_LAST  = 4'h3;
  localparam logic [3:0] PRESC16_LAST = 4'hF;

endpackage

/* verilog/icc_fifo.sv */
// Purpose: four-deep shifting capture buffer for one channel
// Assumes: push is only offered when not full or together with a pop
// Notes:   head word comes straight from a register
`timescale 1ns/100ps
module icc_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         push_i,
  input  wire logic [W-1:0] data_i,
  input  wire logic         pop_i,
  output logic      [W-1:0] head_o,
  output logic              full_o,
  output logic              empty_o
);

  localparam int CW = $clog2(DEPTH) + 1;
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [CW-1:0]           cnt;
  } icc_fifo_s;

  icc_fifo_s q;
  icc_fifo_s d;

  always_comb
  begin
    d = q;
    // oldest word leaves, the rest move one place forward
    if (pop_i && q.cnt != '0)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
        d.mem[i] = q.mem[i+1];
      d.cnt = q.cnt - 1'b1;
    end
    if (push_i && d.cnt != CNT_FULL)
    begin
      for (int i = 0; i < DEPTH; i++)
        if (CW'(i) == d.cnt)
          d.mem[i] = data_i;
      d.cnt = d.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= d;
  end

  assign head_o  = q.mem[0];
  assign full_o  = (q.cnt == CNT_FULL);
  assign empty_o = (q.cnt == '0);

endmodule

/* verilog/icc_top.sv */
// Purpose: four-channel input capture unit with Wishbone registers
// Assumes: capture pins and timebases are synchronous to clk_i
// Notes:   channel_irq_flag pulses feed an external flag register
//
// What this block does
// - four independent channels, each fully separate
// - three-bit mode in control bits two-zero
// - capture every falling, or every rising edge
// - capture every fourth or sixteenth rising edge
// - capture on every edge, both directions
// - three prescale settings inside the mode field
// - prescaler cleared while channel is off
// - reset clears every prescaler
// - four-entry sixteen-bit buffer per channel
// - not-empty flag set until buffer drained
// - read returns oldest, rest move forward
// - capture into full buffer sets overflow, except in every-edge mode
// - overflowing capture is dropped
// - after overflow, store nothing until drained
// - each channel raises capture interrupts
// - control bit seven picks timebase, b default
// - every-edge mode: irq each edge, no overflow
// - control bits six-five set events per irq
// - mode seven: rising-edge interrupt only, wakes
`timescale 1ns/100ps
module icc_top #(
  parameter int ADR_W = 12
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [ADR_W-1:0]           wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic      [31:0]                wb_dat_o,
  output logic                            wb_ack_o,
  input  wire logic [icc_pkg::NCH-1:0]    cap_pin_i,
  input  wire logic [icc_pkg::TS_W-1:0]   timebase_a_i,
  input  wire logic [icc_pkg::TS_W-1:0]   timebase_b_i,
  output logic      [icc_pkg::NCH-1:0]    channel_irq_flag_o,
  output logic      [icc_pkg::NCH-1:0]    buffer_not_empty_flag_o,
  output logic      [icc_pkg::NCH-1:0]    capture_overflow_flag_o
);

  localparam int NCH  = icc_pkg::NCH;
  localparam int TS_W = icc_pkg::TS_W;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NCH-1:0]        pin;
    logic [NCH-1:0][3:0]   presc;
    logic [NCH-1:0][1:0]   evcnt;
    logic [NCH-1:0][2:0]   mode;
    logic [NCH-1:0][1:0]   epi;
    logic [NCH-1:0]        tbsel;
    logic [NCH-1:0]        ovf;
    logic [NCH-1:0]        irq;
    logic                  ack;
    logic [31:0]           dat;
  } icc_state_s;

  icc_state_s q;
  icc_state_s d;

  logic [NCH-1:0]            push;
  logic [NCH-1:0]            pop;
  logic [NCH-1:0]            full;
  logic [NCH-1:0]            empty;
  logic [NCH-1:0][TS_W-1:0]  head;
  logic [NCH-1:0][TS_W-1:0]  stamp;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // one-hot channel match of a byte address against an index table
  function automatic logic [NCH-1:0] chan_hit(
    input logic [ADR_W-1:0]           adr,
    input logic [icc_pkg::IDX_W-1:0]  tbl [0:NCH-1]
  );
    logic [NCH-1:0] h;
    h = '0;
    for (int c = 0; c < NCH; c++)
      h[c] = (adr[1:0] == 2'h0) &&
             (adr[ADR_W-1:2] == (ADR_W-2)'(tbl[c]));
    return h;
  endfunction

  logic [NCH-1:0] hit_buf;
  logic [NCH-1:0] hit_ctrl;
  logic           take;

  assign hit_buf  = chan_hit(wb_adr_i, icc_pkg::BUF_IDX);
  assign hit_ctrl = chan_hit(wb_adr_i, icc_pkg::CTRL_IDX);
  // one access per request: the ack cycle itself is never retaken
  assign take     = wb_cyc_i && wb_stb_i && !q.ack;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic rise;
    logic fall;
    logic hit;
    rise  = 1'b0;
    fall  = 1'b0;
    hit   = 1'b0;
    d     = q;
    d.ack = take;
    d.irq = '0;
    push  = '0;
    pop   = '0;

    // register access comes first so a capture event can win
    if (take)
    begin
      d.dat = 32'h0000_0000;
      for (int c = 0; c < NCH; c++)
      begin
        if (hit_ctrl[c] && wb_we_i && wb_sel_i[0])
        begin
          d.mode[c]  = wb_dat_i[icc_pkg::MODE_LSB +: 3];
          d.epi[c]   = wb_dat_i[icc_pkg::EPI_LSB +: 2];
          d.tbsel[c] = wb_dat_i[icc_pkg::TB_BIT];
          // writing zero to the overflow bit clears it
          if (!wb_dat_i[icc_pkg::OVF_BIT])
            d.ovf[c] = 1'b0;
        end
        if (hit_ctrl[c] && !wb_we_i)
        begin
          d.dat[icc_pkg::MODE_LSB +: 3] = q.mode[c];
          d.dat[icc_pkg::NE_BIT]        = !empty[c];
          d.dat[icc_pkg::OVF_BIT]       = q.ovf[c];
          d.dat[icc_pkg::EPI_LSB +: 2]  = q.epi[c];
          d.dat[icc_pkg::TB_BIT]        = q.tbsel[c];
        end
        if (hit_buf[c] && !wb_we_i)
        begin
          d.dat[TS_W-1:0] = head[c];
          pop[c]          = 1'b1;
        end
      end
    end

    for (int c = 0; c < NCH; c++)
    begin
      rise       = cap_pin_i[c] && !q.pin[c];
      fall       = !cap_pin_i[c] && q.pin[c];
      hit        = 1'b0;
      d.pin[c]   = cap_pin_i[c];
      case (q.mode[c])
        icc_pkg::MODE_OFF:
        begin
          d.presc[c] = 4'h0;
          d.evcnt[c] = 2'h0;
        end
        icc_pkg::MODE_EVERY:  hit = rise || fall;
        icc_pkg::MODE_FALL:   hit = fall;
        icc_pkg::MODE_RISE:   hit = rise;
        icc_pkg::MODE_RISE4:
        begin
          if (rise)
          begin
            hit        = (q.presc[c] >= icc_pkg::PRESC4_LAST);
            d.presc[c] = hit ? 4'h0 : q.presc[c] + 4'h1;
          end
        end
        icc_pkg::MODE_RISE16:
        begin
          if (rise)
          begin
            hit        = (q.presc[c] == icc_pkg::PRESC16_LAST);
            d.presc[c] = hit ? 4'h0 : q.presc[c] + 4'h1;
          end
        end
        icc_pkg::MODE_WAKE:   d.irq[c] = rise;
        default:              hit = 1'b0;
      endcase

      if (hit)
      begin
        if (full[c])
        begin
          if (q.mode[c] != icc_pkg::MODE_EVERY)
            d.ovf[c] = 1'b1;
        end
        else if (!q.ovf[c] || empty[c])
          push[c] = 1'b1;

        if (q.mode[c] == icc_pkg::MODE_EVERY)
          d.irq[c] = 1'b1;
        else if (q.evcnt[c] == q.epi[c])
        begin
          d.irq[c]   = 1'b1;
          d.evcnt[c] = 2'h0;
        end
        else
          d.evcnt[c] = q.evcnt[c] + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q       <= '0;
      q.mode  <= {NCH{icc_pkg::MODE_RESET}};
      q.epi   <= {NCH{icc_pkg::EPI_RESET}};
      q.tbsel <= {NCH{icc_pkg::TB_RESET}};
    end
    else
      q <= d;
  end

  // ----------------------------------------------------------------
  // capture buffers
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      assign stamp[g] = q.tbsel[g] ? timebase_a_i : timebase_b_i;

      icc_fifo #(
        .W     (TS_W),
        .DEPTH (icc_pkg::DEPTH)
      ) u_fifo (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .push_i  (push[g]),
        .data_i  (stamp[g]),
        .pop_i   (pop[g]),
        .head_o  (head[g]),
        .full_o  (full[g]),
        .empty_o (empty[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_dat_o                = q.dat;
  assign wb_ack_o                = q.ack;
  assign channel_irq_flag_o      = q.irq;
  assign buffer_not_empty_flag_o = ~empty;
  assign capture_overflow_flag_o = q.ovf;

endmodule

/* verif/icc_top_asserts.sv */
// Purpose: port checks for the input capture unit
// Assumes: one clock, synchronous active-high reset
// Notes:   bound into icc_top after the module
`timescale 1ns/100ps
module icc_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [3:0]  cap_pin_i,
  input wire logic [3:0]  channel_irq_flag_o,
  input wire logic [3:0]  buffer_not_empty_flag_o,
  input wire logic [3:0]  capture_overflow_flag_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       take;
  logic [3:0] ne;
  logic [3:0] ov;
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign ne   = buffer_not_empty_flag_o;
  assign ov   = capture_overflow_flag_o;
  // ------------
  // assertions
  // ------------
  ack_after_take_a: assert property (
    take |=> wb_ack_o ##1 !wb_ack_o) else $error("bad ack timing");
  read_upper_zero_a: assert property (
    wb_ack_o |-> wb_dat_o[31:16] == 16'h0) else $error("upper bits set");
  irq_needs_edge_a: assert property (
    (channel_irq_flag_o & ~($past(cap_pin_i) ^ $past(cap_pin_i, 2)))
    == 4'h0) else $error("irq without pin edge");
  fill_needs_edge_a: assert property (
    (ne & ~$past(ne) & ~($past(cap_pin_i) ^ $past(cap_pin_i, 2)))
    == 4'h0) else $error("fill without pin edge");
  drain_needs_read_a: assert property (
    |($past(ne) & ~ne) |-> $past(take && !wb_we_i || rst_i))
    else $error("drain without read");
  ovf_needs_full_a: assert property (
    (ov & ~$past(ov) & ~$past(ne)) == 4'h0) else $error("early overflow");
  ovf_sticky_a: assert property (
    |($past(ov) & ~ov) |-> $past(take && wb_we_i || rst_i))
    else $error("overflow lost");
  rst_clears_a: assert property (disable iff (1'b0)
    rst_i |=> !wb_ack_o && ne == 4'h0 && ov == 4'h0)
    else $error("reset left state");
  cover property (|ov);
  cover property (|channel_irq_flag_o);
  cover property (|($past(ne) & ~ne));
endmodule

bind icc_top icc_chk i_icc_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_dat_o, .wb_ack_o, .cap_pin_i, .channel_irq_flag_o,
  .buffer_not_empty_flag_o, .capture_overflow_flag_o);

/* verif/icc_src.sv */
// Purpose: far side: capture pin source and two timebases
// Assumes: a pin flips at the edge that sees its toggle request
// Notes:   b counts down by seven so its words differ from a
`timescale 1ns/100ps
module icc_src (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  tgl_i,
  output logic      [3:0]  pin_o,
  output logic      [15:0] ta_o,
  output logic      [15:0] tb_o
);
  always_ff @(posedge clk_i)
  begin
    ta_o  <= rst_i ? 16'h0 : ta_o + 16'h1;
    tb_o  <= rst_i ? 16'hFFFF : tb_o - 16'h7;
    pin_o <= rst_i ? 4'h0 : pin_o ^ tgl_i;
  end
endmodule

/* verif/tb_icc_top.sv */
// Purpose: random and corner tests of the capture unit
// Assumes: icc_src flips pins and runs both timebases
// Notes:   queues mirror each channel's buffer
`timescale 1ns/100ps
module tb_icc_top;
  logic        clk_i, rst_i, cyc, stb, we, ack;
  logic [11:0] adr;
  logic [31:0] dw, dr, q;
  logic [3:0]  tgl, pin, irq, ne, ov;
  logic [15:0] ta, tb;
  logic [15:0] eq[4][$];
  int          md[4], ep[4], ts[4], ps[4], ev[4], bl[4], xo[4];
  int          xi, ic, miscompares, compares;

  icc_top i_icc_top (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dw),
    .wb_dat_o(dr), .wb_ack_o(ack), .cap_pin_i(pin), .timebase_a_i(ta),
    .timebase_b_i(tb), .channel_irq_flag_o(irq),
    .buffer_not_empty_flag_o(ne), .capture_overflow_flag_o(ov));
  icc_src i_icc_src (.clk_i, .rst_i, .tgl_i(tgl), .pin_o(pin),
    .ta_o(ta), .tb_o(tb));

  initial
  begin
    clk_i = 0;
    forever #20 clk_i = ~clk_i;
  end
  always @(negedge clk_i) if (!rst_i) ic += $countones(irq);

  task chk(input logic [31:0] g, e);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task conclude;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task wb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_i) {cyc, stb, we, adr, dw} <= {2'b11, w, a, d};
    n = 0;
    // ack and read data are both taken at the rising edge that sees ack
    do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
    if (n == 50)
    begin
      miscompares++;
      conclude;
    end
    q = dr;
    {cyc, stb} <= 2'b00;
  endtask
  task cfg(input int c, m, e, t);
    wb({icc_pkg::CTRL_IDX[c], 2'b00}, 1,
      {24'h0, t[0], e[1:0], 2'b00, m[2:0]});
    {md[c], ep[c], ts[c], xo[c]} = {m, e, t, 32'h0};
    if (m == 0) {ps[c], ev[c]} = 0;
  endtask
  task tog(input int c);
    logic r, k;
    @(posedge clk_i) tgl <= 4'h1 << c;
    @(posedge clk_i) tgl <= 4'h0;
    #1 r = pin[c];
    k = md[c] == 1 || md[c] == 2 && !r || md[c] inside {3, 7} && r;
    if (md[c] inside {4, 5} && r)
    begin
      k = ps[c] == (md[c] == 4 ? 3 : 15);
      ps[c] = k ? 0 : ps[c] + 1;
    end
    if (k && md[c] inside {1, 7}) xi++;
    else if (k && ++ev[c] > ep[c]) {xi, ev[c]} = {xi + 1, 32'h0};
    // store or drop, every-edge mode never overflows
    if (k && md[c] inside {[2:5]} && eq[c].size() == 4)
      {xo[c], bl[c]} = {32'h1, 32'h1};
    else if (k && md[c] != 7 && !bl[c] && eq[c].size() < 4)
      eq[c].push_back(ts[c] ? ta : tb);
    @(posedge clk_i);
  endtask
  task rd(input int c);
    wb({icc_pkg::BUF_IDX[c], 2'b00}, 0, 0);
    chk(q, {16'h0, eq[c].pop_front()});
    if (eq[c].size() == 0) bl[c] = 0;
  endtask
  task flags(input int c);
    // second negedge: the irq counter has already seen the last pulse
    repeat (2) @(negedge clk_i);
    chk(ne[c], eq[c].size() != 0);
    chk(ov[c], xo[c]);
    chk(ic, xi);
    wb({icc_pkg::CTRL_IDX[c], 2'b00}, 0, 0);
    chk(q, {ts[c][0], ep[c][1:0], xo[c][0], eq[c].size() != 0,
      md[c][2:0]});
  endtask

  initial
  begin
    int c, m;
    int modes[6];
    modes = '{2, 3, 1, 4, 5, 7};
    {rst_i, cyc, stb, we, tgl, adr, dw} = {4'h8, 4'h0, 12'h0, 32'h0};
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    void'($urandom(32'h79eb7642));
    for (c = 0; c < 4; c++) flags(c);
    wb(12'h7FC, 0, 0);
    chk(q, 0);
    foreach (modes[i])
    begin
      c = $urandom % 4;
      m = modes[i];
      cfg(c, m, m == 7 ? 0 : $urandom % 4, $urandom % 2);
      repeat (m == 5 ? 32 : m == 1 ? 6 : 8) tog(c);
      flags(c);
      while (eq[c].size()) rd(c);
      flags(c);
      cfg(c, 0, 0, 0);
    end
    c = $urandom % 4;
    cfg(c, 3, 0, 1);
    repeat (10) tog(c);
    flags(c);
    rd(c);
    repeat (2) tog(c);
    flags(c);
    while (eq[c].size()) rd(c);
    repeat (2) tog(c);
    flags(c);
    rd(c);
    cfg(c, 4, 0, 0);
    flags(c);
    repeat (4) tog(c);
    cfg(c, 0, 0, 0);
    cfg(c, 4, 0, 0);
    repeat (8) tog(c);
    flags(c);
    rd(c);
    repeat (4) tog(c);
    @(posedge clk_i) rst_i <= 1;
    @(posedge clk_i) rst_i <= 0;
    {md[c], ps[c], ev[c], ts[c], ep[c]} = 0;
    cfg(c, 4, 0, 0);
    repeat (8) tog(c);
    flags(c);
    rd(c);
    conclude;
  end
endmodule
